// *** hw/dpw_register_bank.sv ***
// Wiper counters and data register control for a dual digital pot.
// Assumes a serial front end on the same clock delivers decoded
// instruction bytes, data bytes and step pulses, and uses busy to
// withhold its address acknowledge.
`timescale 1ns/1ps
// Contract
// - One command port serves both pots; each pot has identical wiper and registers.
// - Two independent wiper counters, one per pot.
// - Six-bit wiper, parallel and serial loadable, decoded one-hot onto 64 taps.
// - Direct wiper write loads the selected wiper with the supplied value.
// - Transfer-to-wiper loads the wiper from any of its pot's four registers.
// - Each step of increment/decrement moves the wiper exactly one position, except at either end, where it holds.
// - After power-up each wiper is loaded from its pot's register zero.
// - Wipers are volatile; restored value may differ from the one before.
// - Four retained data registers per pot, eight in all.
// - Host can read and write every data register directly.
// - Transfers run both ways between a pot's registers and its wiper.
// - Every data register change is a write lasting at most 10 ms; a global store holds busy one cycle longer.
// - Instruction byte: opcode nibble, zero bit, pot select, register select.
// - Step with data high moves toward high end, data low toward low end.
// - During a retained write the address acknowledge is withheld via busy.
// - Global transfers act on both pots with the same register index.
module dpw_register_bank
#(
   parameter int NV_WRITE_CYCLES = dpw_pkg::NV_WRITE_CYCLES
)
(
   input  wire logic                                   clk,
   input  wire logic                                   nrst,
   input  wire logic                                   cmd_valid,
   input  wire logic [7:0]                             cmd_instr,
   input  wire logic [7:0]                             cmd_data,
   input  wire logic                                   step_valid,
   input  wire logic                                   step_up,
   output logic                                        busy,
   output logic                                        rd_valid,
   output logic      [dpw_pkg::WIPER_W-1:0]            rd_data,
   output logic      [dpw_pkg::NUM_POTS-1:0][dpw_pkg::WIPER_W-1:0] wiper,
   output logic      [dpw_pkg::NUM_POTS-1:0][dpw_pkg::NUM_TAPS-1:0] taps
);

   localparam logic [dpw_pkg::CNT_W-1:0] WAIT_LOAD =
      dpw_pkg::CNT_W'(NV_WRITE_CYCLES - 1);

   dpw_mem_if mem ();

   dpw_pkg::dpw_state_type                    state;
   dpw_pkg::dpw_state_type                    next_state;
   logic [dpw_pkg::NUM_POTS-1:0][dpw_pkg::WIPER_W-1:0] next_wiper;
   logic                                       step_armed;
   logic                                       next_step_armed;
   logic                                       pot_sel;
   logic                                       next_pot_sel;
   logic [1:0]                                 reg_sel;
   logic [1:0]                                 next_reg_sel;
   logic [dpw_pkg::CNT_W-1:0]                  wait_cnt;
   logic [dpw_pkg::CNT_W-1:0]                  next_wait_cnt;
   logic                                       next_busy;
   logic                                       next_rd_valid;
   logic [dpw_pkg::WIPER_W-1:0]                next_rd_data;

   logic [3:0]                                 opcode;
   logic                                       zero_ok;
   logic                                       cmd_pot;
   logic [1:0]                                 cmd_reg;
   logic                                       cmd_take;
   logic                                       step_take;

   assign opcode  = cmd_instr[dpw_pkg::OPC_MSB:dpw_pkg::OPC_LSB];
   assign zero_ok = ~cmd_instr[dpw_pkg::ZERO_BIT];
   assign cmd_pot = cmd_instr[dpw_pkg::POT_BIT];
   assign cmd_reg = cmd_instr[dpw_pkg::REG_MSB:dpw_pkg::REG_LSB];

   // Instructions and steps are only taken while idle
   assign cmd_take  = cmd_valid && (state == dpw_pkg::DPW_IDLE);
   assign step_take = step_valid && step_armed && !cmd_valid &&
                      (state == dpw_pkg::DPW_IDLE);

   dpw_data_store u_store
   (
      .clk (clk),
      .mem (mem.store)
   );

   genvar p;
   generate
      for (p = 0; p < dpw_pkg::NUM_POTS; p++)
      begin : g_pot
         dpw_tap_decode u_decode
         (
            .clk   (clk),
            .nrst  (nrst),
            .wiper (wiper[p]),
            .taps  (taps[p])
         );
      end
   endgenerate

   always_comb
   begin
      next_state      = state;
      next_wiper      = wiper;
      next_step_armed = step_armed;
      next_pot_sel    = pot_sel;
      next_reg_sel    = reg_sel;
      next_wait_cnt   = wait_cnt;
      mem.addr        = {pot_sel, reg_sel};
      mem.wr_en       = 1'b0;
      mem.wr_data     = wiper[pot_sel];

      unique case (state)
         // Power-up shares the global recall path with register zero
         dpw_pkg::DPW_GLOAD0:
         begin
            mem.addr   = {1'b0, reg_sel};
            next_state = dpw_pkg::DPW_GLOAD1;
         end
         dpw_pkg::DPW_GLOAD1:
         begin
            next_wiper[0] = mem.rd_data;
            mem.addr      = {1'b1, reg_sel};
            next_pot_sel  = 1'b1;
            next_state    = dpw_pkg::DPW_LOAD;
         end
         dpw_pkg::DPW_LOAD:
         begin
            next_wiper[pot_sel] = mem.rd_data;
            next_state          = dpw_pkg::DPW_IDLE;
         end
         dpw_pkg::DPW_RD_DREG:
         begin
            next_state = dpw_pkg::DPW_IDLE;
         end
         dpw_pkg::DPW_GSTORE:
         begin
            mem.addr      = {1'b1, reg_sel};
            mem.wr_en     = 1'b1;
            mem.wr_data   = wiper[1];
            next_wait_cnt = WAIT_LOAD;
            next_state    = dpw_pkg::DPW_NV_WAIT;
         end
         dpw_pkg::DPW_NV_WAIT:
         begin
            // Commands are dropped here, front end sees busy
            if (wait_cnt == '0)
            begin
               next_state = dpw_pkg::DPW_IDLE;
            end
            else
            begin
               next_wait_cnt = wait_cnt - 1'b1;
            end
         end
         dpw_pkg::DPW_IDLE:
         begin
            if (cmd_take)
            begin
               // Any new instruction ends a step sequence
               next_step_armed = 1'b0;
               next_pot_sel    = cmd_pot;
               next_reg_sel    = cmd_reg;
               if (opcode == dpw_pkg::OP_GXFR_TO_WIPER)
               begin
                  next_pot_sel = 1'b0;
                  next_state   = dpw_pkg::DPW_GLOAD0;
               end
               else if (opcode == dpw_pkg::OP_GXFR_TO_DREG)
               begin
                  mem.addr   = {1'b0, cmd_reg};
                  mem.wr_en  = 1'b1;
                  mem.wr_data = wiper[0];
                  next_state = dpw_pkg::DPW_GSTORE;
               end
               else if (zero_ok)
               begin
                  mem.addr = {cmd_pot, cmd_reg};
                  if (opcode == dpw_pkg::OP_WR_WIPER)
                  begin
                     next_wiper[cmd_pot] = cmd_data[dpw_pkg::WIPER_W-1:0];
                  end
                  else if (opcode == dpw_pkg::OP_RD_DREG)
                  begin
                     next_state = dpw_pkg::DPW_RD_DREG;
                  end
                  else if (opcode == dpw_pkg::OP_WR_DREG)
                  begin
                     mem.wr_en     = 1'b1;
                     mem.wr_data   = cmd_data[dpw_pkg::WIPER_W-1:0];
                     next_wait_cnt = WAIT_LOAD;
                     next_state    = dpw_pkg::DPW_NV_WAIT;
                  end
                  else if (opcode == dpw_pkg::OP_XFR_TO_WIPER)
                  begin
                     next_state = dpw_pkg::DPW_LOAD;
                  end
                  else if (opcode == dpw_pkg::OP_XFR_TO_DREG)
                  begin
                     mem.wr_en     = 1'b1;
                     mem.wr_data   = wiper[cmd_pot];
                     next_wait_cnt = WAIT_LOAD;
                     next_state    = dpw_pkg::DPW_NV_WAIT;
                  end
                  else if (opcode == dpw_pkg::OP_STEP)
                  begin
                     next_step_armed = 1'b1;
                  end
               end
            end
            else if (step_take)
            begin
               if (step_up)
               begin
                  if (wiper[pot_sel] != dpw_pkg::WIPER_MAX)
                  begin
                     next_wiper[pot_sel] = wiper[pot_sel] + 1'b1;
                  end
               end
               else if (wiper[pot_sel] != dpw_pkg::WIPER_MIN)
               begin
                  next_wiper[pot_sel] = wiper[pot_sel] - 1'b1;
               end
            end
         end
         default:
         begin
            next_state = dpw_pkg::DPW_IDLE;
         end
      endcase
   end

   // Wipers reset to a fixed value, then recall overwrites it
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state      <= dpw_pkg::DPW_GLOAD0;
         wiper      <= {dpw_pkg::NUM_POTS{dpw_pkg::WIPER_RESET}};
         step_armed <= 1'b0;
         pot_sel    <= 1'b0;
         reg_sel    <= dpw_pkg::REG_ZERO;
         wait_cnt   <= '0;
      end
      else
      begin
         state      <= next_state;
         wiper      <= next_wiper;
         step_armed <= next_step_armed;
         pot_sel    <= next_pot_sel;
         reg_sel    <= next_reg_sel;
         wait_cnt   <= next_wait_cnt;
      end
   end

   // Busy covers every state but idle; the front end withholds its acknowledge
   always_comb
   begin
      next_busy = (next_state != dpw_pkg::DPW_IDLE);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         busy <= 1'b1;
      end
      else
      begin
         busy <= next_busy;
      end
   end

   // Read-back: one pulse per read, data held until the next read
   always_comb
   begin
      next_rd_valid = 1'b0;
      next_rd_data  = rd_data;
      if (state == dpw_pkg::DPW_RD_DREG)
      begin
         next_rd_data  = mem.rd_data;
         next_rd_valid = 1'b1;
      end
      else if (cmd_take && zero_ok && (opcode == dpw_pkg::OP_RD_WIPER))
      begin
         next_rd_data  = wiper[cmd_pot];
         next_rd_valid = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rd_valid <= 1'b0;
         rd_data  <= dpw_pkg::WIPER_RESET;
      end
      else
      begin
         rd_valid <= next_rd_valid;
         rd_data  <= next_rd_data;
      end
   end

endmodule // dpw_register_bank

// *** common/dpw_pkg.sv ***
// Constants and types for the dual pot wiper register bank.
// Assumes a 40 MHz system clock; shared by the bank, its store and decoder.
package dpw_pkg;

   localparam int WIPER_W  = 6;
   localparam int NUM_POTS = 2;
   localparam int NUM_REGS = 4;
   localparam int NUM_TAPS = 64;
   localparam int ADDR_W   = 3;
   localparam int CNT_W    = 19;

   // Instruction byte field positions
   localparam int OPC_MSB  = 7;
   localparam int OPC_LSB  = 4;
   localparam int ZERO_BIT = 3;
   localparam int POT_BIT  = 2;
   localparam int REG_MSB  = 1;
   localparam int REG_LSB  = 0;

   // Opcodes in the upper nibble
   localparam logic [3:0] OP_RD_WIPER      = 4'h9;
   localparam logic [3:0] OP_WR_WIPER      = 4'hA;
   localparam logic [3:0] OP_RD_DREG       = 4'hB;
   localparam logic [3:0] OP_WR_DREG       = 4'hC;
   localparam logic [3:0] OP_XFR_TO_WIPER  = 4'hD;
   localparam logic [3:0] OP_XFR_TO_DREG   = 4'hE;
   localparam logic [3:0] OP_GXFR_TO_WIPER = 4'h1;
   localparam logic [3:0] OP_GXFR_TO_DREG  = 4'h8;
   localparam logic [3:0] OP_STEP          = 4'h2;

   localparam logic [WIPER_W-1:0] WIPER_MIN   = 6'h00;
   localparam logic [WIPER_W-1:0] WIPER_MAX   = 6'h3F;
   localparam logic [WIPER_W-1:0] WIPER_RESET = 6'h00;
   localparam logic [1:0]         REG_ZERO    = 2'h0;

   // Nonvolatile write time
   localparam int NV_WRITE_MS     = 10;
   localparam int CLK_HZ          = 40_000_000;
   localparam int NV_WRITE_CYCLES = NV_WRITE_MS * (CLK_HZ / 1000);

   typedef enum logic [2:0] {
      DPW_GLOAD0,
      DPW_GLOAD1,
      DPW_LOAD,
      DPW_IDLE,
      DPW_RD_DREG,
      DPW_GSTORE,
      DPW_NV_WAIT
   } dpw_state_type;

endpackage

// *** common/dpw_mem_if.sv ***
// Carrier between the bank controller and its data register store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface dpw_mem_if;
   logic [dpw_pkg::ADDR_W-1:0]  addr;
   logic                        wr_en;
   logic [dpw_pkg::WIPER_W-1:0] wr_data;
   logic [dpw_pkg::WIPER_W-1:0] rd_data;

   modport ctrl
   (
      output addr,
      output wr_en,
      output wr_data,
      input  rd_data
   );

   modport store
   (
      input  addr,
      input  wr_en,
      input  wr_data,
      output rd_data
   );
endinterface

// *** hw/dpw_data_store.sv ***
// Eight data registers, four per pot, addressed {pot, register}.
// Assumes single clock; read data registered, one cycle latency.
`timescale 1ns/1ps
module dpw_data_store
(
   input wire logic clk,
   dpw_mem_if.store mem
);

   // No reset: contents model retained storage and survive nrst
   logic [dpw_pkg::WIPER_W-1:0] cells [dpw_pkg::NUM_POTS*dpw_pkg::NUM_REGS];
   logic [dpw_pkg::WIPER_W-1:0] rd_q;

   always_ff @(posedge clk)
   begin
      if (mem.wr_en)
      begin
         cells[mem.addr] <= mem.wr_data;
      end
      rd_q <= cells[mem.addr];
   end

   assign mem.rd_data = rd_q;

endmodule // dpw_data_store

// *** hw/dpw_tap_decode.sv ***
// One-hot decode of a wiper position into tap switch closures.
// Assumes wiper comes from a flop on the same clock; output is registered.
`timescale 1ns/1ps
module dpw_tap_decode
(
   input  wire logic                              clk,
   input  wire logic                              nrst,
   input  wire logic [dpw_pkg::WIPER_W-1:0]       wiper,
   output logic      [dpw_pkg::NUM_TAPS-1:0]      taps
);

   logic [dpw_pkg::NUM_TAPS-1:0] next_taps;

   genvar i;
   generate
      for (i = 0; i < dpw_pkg::NUM_TAPS; i++)
      begin : g_tap
         assign next_taps[i] = (wiper == dpw_pkg::WIPER_W'(i));
      end
   endgenerate

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         taps <= 64'h0000_0000_0000_0001;
      end
      else
      begin
         taps <= next_taps;
      end
   end

endmodule // dpw_tap_decode

// *** test/dpw_monitor.sv ***
// Checker for the dual pot register bank, bound onto its top module.
// Assumes NV_WRITE_CYCLES is handed on from the bank instance.
`timescale 1ns/1ps
module dpw_monitor
#(
   parameter int NV_WRITE_CYCLES = 8
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_instr,
   input wire logic [7:0] cmd_data,
   input wire logic step_valid,
   input wire logic step_up,
   input wire logic busy,
   input wire logic rd_valid,
   input wire logic [dpw_pkg::WIPER_W-1:0] rd_data,
   input wire logic [dpw_pkg::NUM_POTS-1:0][dpw_pkg::WIPER_W-1:0] wiper,
   input wire logic [dpw_pkg::NUM_POTS-1:0][dpw_pkg::NUM_TAPS-1:0] taps
);
   // Busy is sampled high from the edge after the take through this many edges
   localparam int NV_END = NV_WRITE_CYCLES;
   logic       step_on;
   logic       step_pot;
   logic       next_step_on;
   logic       next_step_pot;
   logic       take;
   logic       stake;
   logic       pot;
   logic [4:0] op;
   logic [5:0] dat;
   logic [5:0] pw;
   logic [5:0] sw;
   assign take = cmd_valid && !busy;
   assign op = cmd_instr[7:3];
   assign pot = cmd_instr[2];
   assign dat = cmd_data[5:0];
   assign pw = wiper[pot];
   assign sw = wiper[step_pot];
   assign stake = step_on && step_valid && !cmd_valid && !busy;
   // Any taken instruction other than step ends step mode
   always_comb
   begin
      next_step_on = step_on;
      next_step_pot = step_pot;
      if (take)
      begin
         next_step_on = op == {dpw_pkg::OP_STEP, 1'b0};
         next_step_pot = pot;
      end
   end
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         step_on <= 1'b0;
         step_pot <= 1'b0;
      end
      else
      begin
         step_on <= next_step_on;
         step_pot <= next_step_pot;
      end
   end
   default clocking mcb @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_TAPS: assert property ($stable(wiper) |->
      taps[0] == (64'h1 << wiper[0]) && taps[1] == (64'h1 << wiper[1]))
      else $error("tap decode wrong");
   AST_WR_WIPER: assert property (take && op == {dpw_pkg::OP_WR_WIPER, 1'b0} |=>
      wiper[$past(pot)] == $past(dat)) else $error("wiper write lost");
   AST_RD_WIPER: assert property (take && op == {dpw_pkg::OP_RD_WIPER, 1'b0} |=>
      rd_valid && rd_data == $past(pw)) else $error("wiper read wrong");
   AST_RD_DREG: assert property (take && op == {dpw_pkg::OP_RD_DREG, 1'b0} |=>
      busy ##1 rd_valid && !busy) else $error("register read timing wrong");
   AST_NV_WRITE: assert property (take && (op == {dpw_pkg::OP_WR_DREG, 1'b0} ||
      op == {dpw_pkg::OP_XFR_TO_DREG, 1'b0}) |-> ##NV_END busy ##1 !busy)
      else $error("retained write length wrong");
   AST_STEP_UP: assert property (stake && step_up && sw != 6'h3F |=>
      sw == $past(sw) + 6'h01) else $error("step up wrong");
   AST_STEP_DN: assert property (stake && !step_up && sw != 6'h00 |=>
      sw == $past(sw) - 6'h01) else $error("step down wrong");
   AST_STEP_SAT: assert property (stake && sw == (step_up ? 6'h3F : 6'h00) |=>
      $stable(sw)) else $error("step wrapped");
   AST_RECALL: assert property ($rose(nrst) |-> busy [*3] ##1 !busy)
      else $error("power-up recall timing wrong");
endmodule // dpw_monitor

bind dpw_register_bank dpw_monitor #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) i_mon
(
   .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_instr(cmd_instr),
   .cmd_data(cmd_data), .step_valid(step_valid), .step_up(step_up), .busy(busy),
   .rd_valid(rd_valid), .rd_data(rd_data), .wiper(wiper), .taps(taps)
);

// *** test/dpw_host_model.sv ***
// Host side stand-in: issues decoded instructions and step pulses.
// Assumes the bench clock; drives only at falling edges.
`timescale 1ns/1ps
module dpw_host_model
(
   input wire logic clk,
   input wire logic busy,
   output logic cmd_valid,
   output logic [7:0] cmd_instr,
   output logic [7:0] cmd_data,
   output logic step_valid,
   output logic step_up
);
   int timeouts = 0;
   initial
   begin
      cmd_valid = 1'b0;
      cmd_instr = 8'h00;
      cmd_data = 8'h00;
      step_valid = 1'b0;
      step_up = 1'b0;
   end
   // Polls busy the way a host polls for the address acknowledge
   task automatic idle_wait();
      int n;
      n = 0;
      @(negedge clk);
      while (busy !== 1'b0 && n < 2000)
      begin
         @(negedge clk);
         n++;
      end
      if (n == 2000)
         timeouts++;
   endtask
   task automatic issue(input logic [3:0] op, input logic p, input logic [1:0] s,
                        input logic [7:0] d);
      idle_wait();
      cmd_instr = {op, 1'b0, p, s};
      cmd_data = d;
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
      // Stale bytes inverted so nothing leans on leftovers
      cmd_instr = ~cmd_instr;
      cmd_data = ~d;
   endtask
   task automatic step(input logic up, input int gap);
      idle_wait();
      step_up = up;
      step_valid = 1'b1;
      @(negedge clk);
      step_valid = 1'b0;
      step_up = ~up;
      repeat (gap) @(negedge clk);
   endtask
endmodule // dpw_host_model

// *** test/tb_dual_pot_wiper_register_bank.sv ***
// Self-checking bench for the dual pot register bank.
// Assumes the host model and the bound checker; short retained write time.
`timescale 1ns/1ps
module tb_dual_pot_wiper_register_bank;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cmd_valid, step_valid, step_up, busy, rd_valid;
   logic [7:0] cmd_instr, cmd_data;
   logic [5:0] rd_data;
   logic [1:0][5:0] wiper;
   logic [1:0][63:0] taps;
   int err_total = 0;
   int samples_checked = 0;
   always #12.5 clk = ~clk;
   dpw_register_bank #(.NV_WRITE_CYCLES(8)) i_dut
   (
      .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_instr(cmd_instr),
      .cmd_data(cmd_data), .step_valid(step_valid), .step_up(step_up), .busy(busy),
      .rd_valid(rd_valid), .rd_data(rd_data), .wiper(wiper), .taps(taps)
   );
   dpw_host_model i_host
   (
      .clk(clk), .busy(busy), .cmd_valid(cmd_valid), .cmd_instr(cmd_instr),
      .cmd_data(cmd_data), .step_valid(step_valid), .step_up(step_up)
   );
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         err_total++;
      end
   endtask
   task automatic results();
      err_total += i_host.timeouts;
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic settle();
      repeat (4) @(negedge clk);
      i_host.idle_wait();
   endtask
   task automatic do_reset();
      @(negedge clk);
      nrst = 1'b0;
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      settle();
   endtask
   task automatic rd(input logic [3:0] op, input logic p, input logic [1:0] s,
                     input logic [5:0] exp);
      int n;
      n = 0;
      i_host.issue(op, p, s, 8'h00);
      while (rd_valid !== 1'b1 && n < 8)
      begin
         @(negedge clk);
         n++;
      end
      if (n == 8)
      begin
         err_total++;
         results();
      end
      else
         chk(rd_data, exp);
   endtask
   task automatic t_wiper();
      i_host.issue(dpw_pkg::OP_WR_WIPER, 1'b0, 2'h0, 8'h3F);
      i_host.issue(dpw_pkg::OP_WR_WIPER, 1'b1, 2'h0, 8'hC5);
      settle();
      chk(wiper, {6'h05, 6'h3F});
      chk(taps[0], 64'h8000000000000000);
      chk(taps[1], 64'h20);
      rd(dpw_pkg::OP_RD_WIPER, 1'b0, 2'h0, 6'h3F);
      rd(dpw_pkg::OP_RD_WIPER, 1'b1, 2'h3, 6'h05);
   endtask
   task automatic t_dreg();
      for (int i = 0; i < 8; i++)
         i_host.issue(dpw_pkg::OP_WR_DREG, i[2], i[1:0], 8'(8'h30 + i));
      for (int i = 0; i < 8; i++)
         rd(dpw_pkg::OP_RD_DREG, i[2], i[1:0], 6'(8'h30 + i));
   endtask
   task automatic t_xfr();
      for (int i = 0; i < 4; i++)
      begin
         i_host.issue(dpw_pkg::OP_XFR_TO_WIPER, 1'b1, i[1:0], 8'h00);
         settle();
         chk(wiper[1], 6'(8'h34 + i));
      end
      i_host.issue(dpw_pkg::OP_GXFR_TO_WIPER, 1'b0, 2'h2, 8'h00);
      settle();
      chk(wiper, {6'h36, 6'h32});
      i_host.issue(dpw_pkg::OP_WR_WIPER, 1'b0, 2'h0, 8'h0C);
      i_host.issue(dpw_pkg::OP_XFR_TO_DREG, 1'b0, 2'h3, 8'h00);
      rd(dpw_pkg::OP_RD_DREG, 1'b0, 2'h3, 6'h0C);
      i_host.issue(dpw_pkg::OP_GXFR_TO_DREG, 1'b1, 2'h1, 8'h00);
      rd(dpw_pkg::OP_RD_DREG, 1'b0, 2'h1, 6'h0C);
      rd(dpw_pkg::OP_RD_DREG, 1'b1, 2'h1, 6'h36);
   endtask
   task automatic t_step();
      i_host.issue(dpw_pkg::OP_WR_WIPER, 1'b0, 2'h0, 8'h3E);
      i_host.issue(dpw_pkg::OP_STEP, 1'b0, 2'h0, 8'h00);
      i_host.step(1'b1, 0);
      i_host.step(1'b1, 2);
      settle();
      chk(wiper[0], 6'h3F);
      repeat (3) i_host.step(1'b0, 1);
      settle();
      chk(wiper, {6'h36, 6'h3C});
      i_host.issue(dpw_pkg::OP_WR_WIPER, 1'b1, 2'h0, 8'h01);
      i_host.issue(dpw_pkg::OP_STEP, 1'b1, 2'h0, 8'h00);
      repeat (2) i_host.step(1'b0, 0);
      settle();
      chk(wiper, {6'h00, 6'h3C});
      // Unknown opcode must end step mode, so the next step is ignored
      i_host.issue(4'h0, 1'b1, 2'h0, 8'h00);
      i_host.step(1'b1, 0);
      settle();
      chk(wiper, {6'h00, 6'h3C});
   endtask
   task automatic t_recall();
      i_host.issue(dpw_pkg::OP_WR_DREG, 1'b0, 2'h0, 8'h11);
      i_host.issue(dpw_pkg::OP_WR_DREG, 1'b1, 2'h0, 8'h22);
      settle();
      do_reset();
      chk(wiper, {6'h22, 6'h11});
   endtask
   initial
   begin
      do_reset();
      t_wiper();
      t_dreg();
      t_xfr();
      t_step();
      t_recall();
      results();
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      err_total++;
      results();
   end
endmodule // tb_dual_pot_wiper_register_bank
